// >>> hdl/sequencer_irq_flag_bank.sv
// sticky interrupt flag bank for the sample sequencing engine
// assumes an apb master on pclk, converter pins asynchronous to pclk
// and user flag set pulses from sequencer logic on pclk
//
// How it works
// - 21 interrupt lines, each flag and mask
// - mask one passes flag, zero blocks it
// - calibrate rise sets bits 20, 19, 18
// - calibrate fall sets bits 17, 16, 15
// - result valid rise sets bits 14..12
// - bits 11..0 are sequencer user flags
// - converter events never touch user flags
// - clear register is write-only, bit per flag
// - writing one clears the matching flag
// - writing zero leaves the flag alone
// - set beats a simultaneous clear
// - flags, mask and clear reset to zero
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none

module sequencer_irq_flag_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire irq_bank_pkg::conv_pins_t conv_pins,
   input wire logic [11:0] user_flag_set,
   output logic [20:0] irq_lines,
   output logic irq_summary
);

   logic [20:0] flags_ff;
   logic [20:0] nxt_flags;
   logic [20:0] mask_ff;
   logic [20:0] nxt_mask;
   logic [20:0] set_vec;
   logic [20:0] clr_vec;
   logic [2:0] evt_ff;
   logic [2:0] nxt_evt;
   logic [2:0] evt_mask_ff;
   logic [2:0] nxt_evt_mask;
   logic [2:0] new_evt;
   logic [2:0] evt_rd_clr;
   logic [2:0] cal_rise;
   logic [2:0] cal_fall;
   logic [2:0] dv_rise;
   logic [31:0] prdata_ff;
   logic [31:0] rd_value;
   logic pready_ff;
   logic pslverr_ff;
   logic rd_err;
   logic done;
   irq_bank_pkg::apb_req_t req;

   // converter pins cross into pclk before edge detection
   for (genvar i = 0; i < irq_bank_pkg::NUM_CONV; i++) begin : g_conv
      edge_catch u_cal (
         .pclk(pclk),
         .presetn(presetn),
         .pin_async(conv_pins.calibrating[i]),
         .rise(cal_rise[i]),
         .fall(cal_fall[i])
      );
      edge_catch u_dv (
         .pclk(pclk),
         .presetn(presetn),
         .pin_async(conv_pins.result_valid[i]),
         .rise(dv_rise[i]),
         .fall() // end of result valid raises no flag
      );
   end

   // request view of the bus; done marks the completing edge
   assign req = {paddr, pwrite, pwdata};
   assign done = psel & penable & pready_ff;

   // set sources, converter events kept out of the user field
   always_comb begin
      set_vec = irq_bank_pkg::FLAGS_RST;
      set_vec[irq_bank_pkg::CAL_START_LSB +: 3] = cal_rise;
      set_vec[irq_bank_pkg::CAL_END_LSB +: 3] = cal_fall;
      set_vec[irq_bank_pkg::DONE_LSB +: 3] = dv_rise;
      set_vec[irq_bank_pkg::USER_LSB +: 12] = user_flag_set;
   end

   // clear strobes only on a completed write to the clear register
   always_comb begin
      clr_vec = irq_bank_pkg::FLAGS_RST;
      if (done && req.write && req.addr == irq_bank_pkg::CLEAR_OFS) begin
         clr_vec = req.wdata[20:0];
      end
   end

   // set is or-ed in after the clear so it wins the tie
   assign nxt_flags = (flags_ff & ~clr_vec) | set_vec;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= irq_bank_pkg::FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // mask register; upper write bits are dropped
   always_comb begin
      nxt_mask = mask_ff;
      if (done && req.write && req.addr == irq_bank_pkg::MASK_OFS) begin
         nxt_mask = req.wdata[20:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= irq_bank_pkg::MASK_RST;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // interrupt lines from a flop, aligned with the flag and mask flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_lines <= irq_bank_pkg::FLAGS_RST;
      end else begin
         irq_lines <= nxt_flags & nxt_mask;
      end
   end

   // group events for the summary interrupt
   assign new_evt[irq_bank_pkg::EVT_CALIB] = |(cal_rise | cal_fall);
   assign new_evt[irq_bank_pkg::EVT_DONE] = |dv_rise;
   assign new_evt[irq_bank_pkg::EVT_USER] = |user_flag_set;

   // read clears only what the read returned, so a late event survives
   always_comb begin
      evt_rd_clr = irq_bank_pkg::EVT_RST;
      if (done && !req.write && req.addr == irq_bank_pkg::EVT_STATUS_OFS) begin
         evt_rd_clr = prdata_ff[2:0];
      end
      nxt_evt = (evt_ff & ~evt_rd_clr) | new_evt;
   end

   always_comb begin
      nxt_evt_mask = evt_mask_ff;
      if (done && req.write && req.addr == irq_bank_pkg::EVT_MASK_OFS) begin
         nxt_evt_mask = req.wdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_ff <= irq_bank_pkg::EVT_RST;
         evt_mask_ff <= irq_bank_pkg::EVT_RST;
         irq_summary <= 1'b0;
      end else begin
         evt_ff <= nxt_evt;
         evt_mask_ff <= nxt_evt_mask;
         irq_summary <= |(nxt_evt & nxt_evt_mask);
      end
   end

   // read mux; clear register and unused bits read as zero
   always_comb begin
      rd_value = irq_bank_pkg::RDATA_RST;
      rd_err = 1'b0;
      if (req.addr == irq_bank_pkg::MASK_OFS) begin
         rd_value[20:0] = mask_ff;
      end else if (req.addr == irq_bank_pkg::FLAGS_OFS) begin
         rd_value[20:0] = flags_ff;
      end else if (req.addr == irq_bank_pkg::CLEAR_OFS) begin
         rd_value = irq_bank_pkg::RDATA_RST;
      end else if (req.addr == irq_bank_pkg::EVT_STATUS_OFS) begin
         rd_value[2:0] = evt_ff;
      end else if (req.addr == irq_bank_pkg::EVT_MASK_OFS) begin
         rd_value[2:0] = evt_mask_ff;
      end else begin
         rd_err = 1'b1;
      end
   end

   // one wait state so pready, prdata and pslverr all come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= irq_bank_pkg::RDATA_RST;
      end else if (psel && penable && !pready_ff) begin
         pready_ff <= 1'b1;
         pslverr_ff <= rd_err;
         prdata_ff <= req.write ? irq_bank_pkg::RDATA_RST : rd_value;
      end else begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= irq_bank_pkg::RDATA_RST;
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   // checks
   property p_irq_and;
      @(posedge pclk) disable iff (!presetn)
      irq_lines == (flags_ff & mask_ff);
   endproperty
   a_irq_and: assert property (p_irq_and)
      else $error("irq line differs from flag and mask");

   property p_masked_quiet;
      @(posedge pclk) disable iff (!presetn)
      (irq_lines & ~mask_ff) == 21'h000000;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("masked flag reached an irq line");

   property p_cal_start;
      @(posedge pclk) disable iff (!presetn)
      (cal_rise != 3'h0) |=> ((flags_ff[20:18] & $past(cal_rise))
         == $past(cal_rise));
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration start flag not set");

   property p_cal_end;
      @(posedge pclk) disable iff (!presetn)
      (cal_fall != 3'h0) |=> ((flags_ff[17:15] & $past(cal_fall))
         == $past(cal_fall));
   endproperty
   a_cal_end: assert property (p_cal_end)
      else $error("calibration end flag not set");

   property p_conv_done;
      @(posedge pclk) disable iff (!presetn)
      (dv_rise != 3'h0) |=> ((flags_ff[14:12] & $past(dv_rise))
         == $past(dv_rise));
   endproperty
   a_conv_done: assert property (p_conv_done)
      else $error("conversion done flag mismatch");

   property p_user_set;
      @(posedge pclk) disable iff (!presetn)
      (user_flag_set != 12'h000) |=> ((flags_ff[11:0]
         & $past(user_flag_set)) == $past(user_flag_set));
   endproperty
   a_user_set: assert property (p_user_set)
      else $error("user flag not set");

   property p_user_only;
      @(posedge pclk) disable iff (!presetn)
      (flags_ff[11:0] & ~$past(flags_ff[11:0])
         & ~$past(user_flag_set)) == 12'h000;
   endproperty
   a_user_only: assert property (p_user_only)
      else $error("user flag set without its source");

   property p_clear_reads_zero;
      @(posedge pclk) disable iff (!presetn)
      (done && !pwrite && paddr == irq_bank_pkg::CLEAR_OFS)
         |-> prdata == 32'h00000000;
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero)
      else $error("clear register read not zero");

   property p_clear_one;
      @(posedge pclk) disable iff (!presetn)
      (clr_vec != 21'h000000) |=>
         (flags_ff & $past(clr_vec & ~set_vec)) == 21'h000000;
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("written one did not clear flag");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      ($past(flags_ff) & ~flags_ff & ~$past(clr_vec)) == 21'h000000;
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without a clear");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      ((set_vec & clr_vec) != 21'h000000) |=>
         ((flags_ff & $past(set_vec)) == $past(set_vec));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a simultaneous set");

   property p_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:21] == 11'h000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("reserved read bits not zero");

   c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
      (set_vec & clr_vec) != 21'h000000);
   c_irq_up: cover property (@(posedge pclk) disable iff (!presetn)
      irq_lines != 21'h000000);
   c_summary: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq_summary));
   c_done_flag: cover property (@(posedge pclk) disable iff (!presetn)
      dv_rise != 3'h0);

endmodule

`default_nettype wire

// >>> hdl/irq_bank_pkg.sv
// constants, register map and carrier types of the sequencer irq flag bank
// assumes one pclk domain and an apb slave port with 32-bit data
`default_nettype none

package irq_bank_pkg;

   // widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int FLAG_W = 21;
   localparam int NUM_CONV = 3;
   localparam int USER_W = 12;
   localparam int EVT_W = 3;

   // register byte offsets
   localparam logic [11:0] MASK_OFS = 12'h000;
   localparam logic [11:0] FLAGS_OFS = 12'h004;
   localparam logic [11:0] CLEAR_OFS = 12'h008;
   localparam logic [11:0] EVT_STATUS_OFS = 12'h00C;
   localparam logic [11:0] EVT_MASK_OFS = 12'h010;

   // field positions inside the flag register
   localparam int CAL_START_LSB = 18;
   localparam int CAL_END_LSB = 15;
   localparam int DONE_LSB = 12;
   localparam int USER_LSB = 0;

   // bits of the block event status register
   localparam int EVT_CALIB = 0;
   localparam int EVT_DONE = 1;
   localparam int EVT_USER = 2;

   // reset values
   localparam logic [20:0] FLAGS_RST = 21'h000000;
   localparam logic [20:0] MASK_RST = 21'h000000;
   localparam logic [2:0] EVT_RST = 3'h0;
   localparam logic [31:0] RDATA_RST = 32'h00000000;

   // converter status pins, one bit per converter
   typedef struct packed {
      logic [2:0] calibrating;
      logic [2:0] result_valid;
   } conv_pins_t;

   // one decoded apb request
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_t;

endpackage

`default_nettype wire

// >>> hdl/edge_catch.sv
// two-stage synchroniser with rise and fall detection for one pin
// assumes the pin is asynchronous to pclk and changes slower than pclk
`default_nettype none

module edge_catch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_async,
   output logic rise,
   output logic fall
);

   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;

   // first stage is read only by the second one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         sync1_ff <= pin_async;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // one-cycle pulses on each synchronised transition
   assign rise = sync2_ff & ~prev_ff;
   assign fall = ~sync2_ff & prev_ff;

endmodule

`default_nettype wire

// >>> verification/conv_model.sv
// far side model: converter status pins and sequencer user flag pulses
// assumes pclk from the bench; pins change right after a rising edge
`default_nettype none

module conv_model (
   input wire logic pclk,
   output var irq_bank_pkg::conv_pins_t conv_pins,
   output var logic [11:0] user_flag_set
);
   timeunit 1ns;
   timeprecision 1ns;

   // converters idle at power-up, no calibration running
   initial begin
      conv_pins = '0;
      user_flag_set = '0;
   end

   // pin 0..2 calibrate of converter n, 3..5 result valid of converter n-3
   task automatic set_pin(input int idx, input logic val);
      @(posedge pclk);
      if (idx < 3) begin
         conv_pins.calibrating[idx] <= val;
      end else begin
         conv_pins.result_valid[idx-3] <= val;
      end
   endtask

   // hold set request for n rising edges, then drop it
   task automatic pulse_user(input logic [11:0] m, input int n);
      @(posedge pclk);
      user_flag_set <= m;
      repeat (n) @(posedge pclk);
      user_flag_set <= 12'h000;
   endtask
endmodule

`default_nettype wire

// >>> verification/test_sequencer_irq_flag_bank.sv
// self-checking bench for the sequencer irq flag bank
// assumes the design answers apb with one wait state, events in 3 edges
`default_nettype none

module test_sequencer_irq_flag_bank;
   timeunit 1ns;
   timeprecision 1ns;

   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   irq_bank_pkg::conv_pins_t conv_pins;
   logic [11:0] user_flag_set;
   logic [20:0] irq_lines;
   logic irq_summary;
   int errors = 0, cmp_count = 0;

   always #50 pclk = ~pclk;

   sequencer_irq_flag_bank i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_pins(conv_pins),
      .user_flag_set(user_flag_set), .irq_lines(irq_lines),
      .irq_summary(irq_summary));

   conv_model i_far (.pclk(pclk), .conv_pins(conv_pins),
      .user_flag_set(user_flag_set));

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready without assuming the latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(32'h0, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask

   // after an event: flag, line, summary and event status, then clear it
   task automatic hit(input int b, input int e);
      repeat (5) @(posedge pclk);
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h1 << b);
      chk({11'h000, irq_lines}, 32'h1 << b);
      chk({31'h0, irq_summary}, 32'h1);
      rchk(irq_bank_pkg::EVT_STATUS_OFS, 32'h1 << e);
      apb(1'b1, irq_bank_pkg::CLEAR_OFS, 32'h1 << b);
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h0);
   endtask

   // reset is asynchronous; released after two edges
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(irq_bank_pkg::MASK_OFS, 32'h0);
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h0);
      rchk(irq_bank_pkg::CLEAR_OFS, 32'h0);
      apb(1'b1, irq_bank_pkg::MASK_OFS, 32'hFFFFFFFF);
      rchk(irq_bank_pkg::MASK_OFS, 32'h001FFFFF);
      apb(1'b1, irq_bank_pkg::EVT_MASK_OFS, 32'h00000007);
      $display("test reset and mask done");
      for (int i = 0; i < 3; i++) begin
         i_far.set_pin(i, 1'b1);
         hit(18 + i, 0);
         i_far.set_pin(i, 1'b0);
         hit(15 + i, 0);
         i_far.set_pin(3 + i, 1'b1);
         hit(12 + i, 1);
         i_far.set_pin(3 + i, 1'b0);
         repeat (5) @(posedge pclk);
         rchk(irq_bank_pkg::FLAGS_OFS, 32'h0);
      end
      $display("test converter events done");
      for (int b = 0; b < 12; b++) begin
         i_far.pulse_user(12'h001 << b, 1);
         hit(b, 2);
      end
      $display("test user flags done");
      i_far.pulse_user(12'h001, 1);
      apb(1'b1, irq_bank_pkg::CLEAR_OFS, 32'h001FFFFE);
      apb(1'b1, irq_bank_pkg::FLAGS_OFS, 32'h00000000);
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h1);
      // set pulse lands only on the edge at which the clear completes
      fork
         begin
            repeat (2) @(posedge pclk);
            i_far.pulse_user(12'h002, 1);
         end
         apb(1'b1, irq_bank_pkg::CLEAR_OFS, 32'h00000002);
      join
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h3);
      apb(1'b1, irq_bank_pkg::MASK_OFS, 32'h00000001);
      rchk(irq_bank_pkg::FLAGS_OFS, 32'h3);
      chk({11'h000, irq_lines}, 32'h1);
      apb(1'b1, irq_bank_pkg::MASK_OFS, 32'h00000000);
      apb(1'b1, irq_bank_pkg::EVT_MASK_OFS, 32'h00000000);
      rchk(irq_bank_pkg::EVT_STATUS_OFS, 32'h4);
      chk({11'h000, irq_lines}, 32'h0);
      i_far.pulse_user(12'h004, 1);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq_summary}, 32'h0);
      rchk(irq_bank_pkg::EVT_STATUS_OFS, 32'h4);
      $display("test clear priority and masking done");
      apb(1'b0, 12'h014, 32'h00000000);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test unmapped access done");
      wrap_up();
   end

   // cut a hang short; the whole run needs well under this span
   initial begin
      #300us;
      errors++;
      wrap_up();
   end
endmodule

`default_nettype wire
